// ---- src/brch_handler.sv ----
// module: query and buffer readout command handler with axi4-lite registers
`default_nettype none

// Summary of operation
// RULE1 - output query returns X, Y, R, phase
// RULE2 - display query returns display one or two
// RULE3 - snapshot takes two to six selectors, one instant
// RULE4 - snapshot selectors map one to eleven quantities
// RULE5 - snapshot answers in request order, comma separated
// RULE6 - X/Y and R/phase each latched together
// RULE7 - frequency and aux taken as upstream holds them
// RULE8 - aux query takes selector one to four
// RULE9 - stored count answered anytime, zero after reset
// RULE10 - bin zero oldest, N-1 newest
// RULE11 - buffer read needs valid selector, start, count
// RULE12 - ascii read gives points, last one terminated
// RULE13 - ieee read gives four bytes per point
// RULE14 - idle flag clear until binary transfer ends
// RULE15 - end flag rides with final byte
// RULE16 - binary bytes leave back to back
// RULE17 - host pauses loop storage before reading
// RULE18 - compact point: mantissa, exponent, zero byte
// RULE19 - compact value is mantissa times shifted power
// RULE20 - these queries have no set form
// RULE21 - buffer reset discards points anytime
// RULE22 - bad selector or missing parameter flags error
// RULE23 - binary points ascending, low byte first
module brch_handler
    import brch_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write channels
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    // axi4-lite read channels
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [31:0]       rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready,
    // measurement path
    input  wire brch_meas_t        meas,
    input  wire logic              sample_stb,
    // words to the ascii float formatter
    output var  brch_word_t        fmt_out,
    output var  logic              fmt_valid,
    // raw bytes to the host link
    output var  brch_byte_t        bin_out,
    output var  logic              bin_valid
);
    function automatic logic in_range(input logic [3:0] s, input logic [3:0] max);
        return (s != '0) && (s <= max);
    endfunction : in_range

    // compact m*2^(e-bias) to ieee single; exponent overflow saturates to infinity
    function automatic logic [31:0] to_ieee(input logic [31:0] c);
        logic [15:0] a;
        logic [4:0]  p;
        logic [8:0]  e;
        logic [38:0] sh;
        a  = c[15] ? 16'(-c[15:0]) : c[15:0];
        p  = '0;
        for (int i = 0; i < 16; i++) begin
            if (a[i]) begin
                p = 5'(i);
            end
        end
        e  = 9'(p) + 9'(c[23:16]) + IEEE_EXP_BIAS - CMP_EXP_BIAS;
        sh = 39'(a) << (5'(FRAC_W) - p);
        if (a == '0) begin
            return '0;
        end else if (e > IEEE_EXP_MAX) begin
            return {c[15], IEEE_EXP_INF, 23'h00_0000};
        end
        return {c[15], e[7:0], sh[FRAC_W-1:0]};
    endfunction : to_ieee

    brch_state_t             state_q;
    brch_op_t                op_q;
    brch_op_t                op_in;
    logic                    aw_have_q;
    logic                    w_have_q;
    logic [ADDR_W-1:0]       aw_addr_q;
    logic [31:0]             w_data_q;
    logic [31:0]             cmd_q;
    logic [31:0]             sel_q;
    logic [31:0]             range_q;
    logic                    err_q;
    logic                    run_q;
    logic [CNT_W-1:0]        count_q;
    logic [PTR_W-1:0]        wr_ptr_q;
    logic [31:0]             mem_q [2][BUF_DEPTH];
    logic [NSLOT-1:0][31:0]  slot_q;
    logic [MAX_SEL-1:0][3:0] list_q;
    logic [MAX_SEL-1:0][3:0] list_d;
    logic [2:0]              n_q;
    logic [2:0]              n_d;
    logic [2:0]              idx_q;
    logic                    chan_q;
    logic [PTR_W-1:0]        ptr_q;
    logic [15:0]             left_q;
    logic [1:0]              byte_q;
    logic                    wr_fire;
    logic                    cmd_go;
    logic                    cmd_ok;
    logic                    cmd_take;
    logic [31:0]             raw_pt;
    logic [31:0]             pt_word;
    logic [31:0]             rd_word;
    logic                    rd_hit;
    logic [3:0]              s0;
    logic [2:0]              nsel;
    logic [15:0]             j_in;
    logic [15:0]             k_in;
    logic                    coherent_snapshot_query_ok;

    assign wr_fire  = aw_have_q && w_have_q && !bvalid;
    assign cmd_go   = wr_fire && (aw_addr_q == REG_CMD);
    assign cmd_take = cmd_go && cmd_ok && (state_q == S_IDLE);
    assign s0       = sel_q[SEL_W-1:0];
    assign nsel     = sel_q[NSEL_LSB +: NSEL_W];
    assign j_in     = range_q[RANGE_CNT_LSB-1:0];
    assign k_in     = range_q[RANGE_CNT_LSB +: 16];
    assign raw_pt   = mem_q[chan_q][ptr_q];

    // write side of the bus: address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b0;
            wready    <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end else begin
            awready <= awvalid && !awready && !aw_have_q && !bvalid;
            wready  <= wvalid && !wready && !w_have_q && !bvalid;
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                w_data_q <= wdata;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= (aw_addr_q <= REG_STORE && aw_addr_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    logic wstrb_seen_q;
    // parameter registers; writes of partial strobes are taken whole
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_q   <= '0;
            sel_q   <= '0;
            range_q <= '0;
        end else if (wr_fire && wstrb_seen_q) begin
            unique case (aw_addr_q)
                REG_CMD:   cmd_q   <= w_data_q;
                REG_SEL:   sel_q   <= w_data_q;
                REG_RANGE: range_q <= w_data_q;
                default:   ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstrb_seen_q <= 1'b0;
        end else if (wvalid && wready) begin
            wstrb_seen_q <= (wstrb != '0);
        end
    end

    // read side of the bus
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = '0;
        unique case (araddr)
            REG_CMD:    rd_word = cmd_q;
            REG_SEL:    rd_word = sel_q;
            REG_RANGE:  rd_word = range_q;
            REG_STATUS: begin
                rd_word[ST_IDLE_BIT] = (state_q == S_IDLE);
                rd_word[ST_ERR_BIT]  = err_q;
                rd_word[ST_RUN_BIT]  = run_q;
            end
            REG_COUNT:  rd_word = 32'(count_q);
            REG_STORE:  rd_word = '0;
            default:    rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= arvalid && !arready && !rvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= rd_word;
                rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // display buffers; loop mode keeps the newest BUF_DEPTH points
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q    <= 1'b0;
            count_q  <= '0;
            wr_ptr_q <= '0;
        // RULE21 reset discards points
        end else if (wr_fire && aw_addr_q == REG_STORE && w_data_q[STO_RESET_BIT]) begin
            run_q    <= 1'b0;
            count_q  <= '0;
            wr_ptr_q <= '0;
        end else begin
            if (wr_fire && aw_addr_q == REG_STORE && w_data_q[STO_START_BIT]) begin
                run_q <= 1'b1;
            end else if (wr_fire && aw_addr_q == REG_STORE && w_data_q[STO_PAUSE_BIT]) begin
                run_q <= 1'b0;
            end
            if (run_q && sample_stb) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
                if (count_q != CNT_W'(BUF_DEPTH)) begin
                    count_q <= count_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (run_q && sample_stb) begin
            mem_q[0][wr_ptr_q] <= meas.disp1;
            mem_q[1][wr_ptr_q] <= meas.disp2;
        end
    end

    // command check and answer list
    always_comb begin
        op_in   = brch_op_t'(w_data_q[CMD_OP_W-1:0]);
        list_d  = sel_q[MAX_SEL*SEL_W-1:0];
        n_d     = 3'h1;
        coherent_snapshot_query_ok = (nsel >= COHERENT_SNAPSHOT_QUERY_MIN) && (nsel <= COHERENT_SNAPSHOT_QUERY_MAX);
        for (int i = 0; i < MAX_SEL; i++) begin
            if (3'(i) < nsel && !in_range(list_d[i], SEL_COHERENT_SNAPSHOT_QUERY_MAX)) begin
                coherent_snapshot_query_ok = 1'b0;
            end
        end
        unique case (op_in)
            // RULE1 output selectors
            OP_OUTPUT:  cmd_ok = nsel == 3'h1 && in_range(s0, SEL_OUT_MAX);
            // RULE2 display selectors
            OP_DISPLAY: begin
                cmd_ok    = nsel == 3'h1 && in_range(s0, SEL_DISP_MAX);
                list_d[0] = s0 + SLOT_DISP_BASE;
            end
            // RULE3 RULE4 snapshot selectors
            OP_COHERENT_SNAPSHOT_QUERY: begin
                cmd_ok = coherent_snapshot_query_ok;
                n_d    = nsel;
            end
            // RULE8 aux selector
            OP_AUX: begin
                cmd_ok    = nsel == 3'h1 && in_range(s0, SEL_AUX_MAX);
                list_d[0] = s0 + SLOT_AUX_BASE;
            end
            // RULE9 count anytime
            OP_COUNT: begin
                cmd_ok    = 1'b1;
                list_d[0] = SLOT_COUNT;
            end
            // RULE11 buffer read range
            OP_ASCII, OP_IEEE, OP_COMPACT:
                cmd_ok = nsel == 3'h1 && in_range(s0, SEL_BUF_MAX) && k_in != '0
                         && (17'(j_in) + 17'(k_in)) <= 17'(count_q);
            default:    cmd_ok = 1'b0;
        endcase
        // RULE20 query only
        if (w_data_q[CMD_SET_BIT]) begin
            cmd_ok = 1'b0;
        end
    end

    // RULE22 error flag, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_q <= 1'b0;
        end else if (cmd_go && !cmd_take) begin
            err_q <= 1'b1;
        end else if (wr_fire && aw_addr_q == REG_STATUS && w_data_q[ST_ERR_BIT]) begin
            err_q <= 1'b0;
        end
    end

    // RULE6 RULE7 every quantity latched at one edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_q <= '0;
        end else if (cmd_take) begin
            slot_q <= {to_ieee(meas.disp2), to_ieee(meas.disp1), meas.freq, meas.aux,
                       meas.phase, meas.r, meas.y, meas.x, 32'(count_q)};
        end
    end

    // RULE18 RULE19 point forms
    assign pt_word = (op_q == OP_COMPACT) ? {8'h00, raw_pt[23:0]} : to_ieee(raw_pt);

    // answer sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= S_IDLE;
            op_q      <= OP_COUNT;
            list_q    <= '0;
            n_q       <= 3'h1;
            idx_q     <= '0;
            chan_q    <= 1'b0;
            ptr_q     <= '0;
            left_q    <= '0;
            byte_q    <= '0;
            fmt_out   <= '0;
            fmt_valid <= 1'b0;
            bin_out   <= '0;
            bin_valid <= 1'b0;
        end else begin
            fmt_valid <= 1'b0;
            bin_valid <= 1'b0;
            unique case (state_q)
                S_IDLE: begin
                    if (cmd_take) begin
                        op_q   <= op_in;
                        list_q <= list_d;
                        n_q    <= n_d;
                        idx_q  <= '0;
                        chan_q <= (s0 == SEL_BUF_MAX);
                        // RULE10 bin zero is oldest
                        ptr_q  <= wr_ptr_q - PTR_W'(count_q) + j_in[PTR_W-1:0];
                        left_q <= k_in;
                        byte_q <= '0;
                        state_q <= (op_in inside {OP_ASCII, OP_IEEE, OP_COMPACT}) ? S_BUF : S_WORD;
                    end
                end
                S_WORD: begin
                    // RULE5 request order, last marked
                    fmt_valid    <= 1'b1;
                    fmt_out.data <= slot_q[list_q[idx_q]];
                    fmt_out.last <= (idx_q == n_q - 1'b1);
                    idx_q        <= idx_q + 1'b1;
                    if (idx_q == n_q - 1'b1) begin
                        state_q <= S_IDLE;
                    end
                end
                S_BUF: begin
                    if (op_q == OP_ASCII) begin
                        // RULE12 one point per word
                        fmt_valid    <= 1'b1;
                        fmt_out.data <= to_ieee(raw_pt);
                        fmt_out.last <= (left_q == 16'h0001);
                        ptr_q        <= ptr_q + 1'b1;
                        left_q       <= left_q - 1'b1;
                        if (left_q == 16'h0001) begin
                            state_q <= S_IDLE;
                        end
                    end else begin
                        // RULE13 RULE16 RULE23 four bytes per point, low first
                        bin_valid    <= 1'b1;
                        bin_out.data <= pt_word[{byte_q, 3'b000} +: 8];
                        // RULE15 end flag on final byte
                        bin_out.last <= (left_q == 16'h0001) && (byte_q == 2'h3);
                        byte_q       <= byte_q + 1'b1;
                        if (byte_q == 2'h3) begin
                            ptr_q  <= ptr_q + 1'b1;
                            left_q <= left_q - 1'b1;
                            // RULE14 idle only after last byte
                            if (left_q == 16'h0001) begin
                                state_q <= S_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // checking aids: bytes and words sent since the command was taken
    logic [XFER_W-1:0] tx_cnt_q;
    logic [XFER_W-1:0] wd_cnt_q;
    logic [15:0]       k_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || cmd_take) begin
            tx_cnt_q <= '0;
            wd_cnt_q <= '0;
            k_q      <= aresetn ? k_in : '0;
        end else begin
            tx_cnt_q <= tx_cnt_q + XFER_W'(bin_valid);
            wd_cnt_q <= wd_cnt_q + XFER_W'(fmt_valid);
        end
    end

    property p_idle_busy;
        @(posedge aclk) disable iff (!aresetn) bin_valid && !bin_out.last |-> state_q == S_BUF;
    endproperty
    a_idle_busy: assert property (p_idle_busy) else $error("idle flag set mid transfer"); // RULE14

    property p_four_k;
        @(posedge aclk) disable iff (!aresetn) bin_valid && bin_out.last |-> tx_cnt_q + 1'b1 == {k_q, 2'b00};
    endproperty
    a_four_k: assert property (p_four_k) else $error("binary length not four per bin"); // RULE13

    property p_eoi_end;
        @(posedge aclk) disable iff (!aresetn) bin_valid && bin_out.last |=> !bin_valid [*2];
    endproperty
    a_eoi_end: assert property (p_eoi_end) else $error("byte after end flag"); // RULE15

    property p_no_gap;
        @(posedge aclk) disable iff (!aresetn) bin_valid && !bin_out.last |=> bin_valid;
    endproperty
    a_no_gap: assert property (p_no_gap) else $error("gap in binary stream"); // RULE16

    property p_zero_top;
        @(posedge aclk) disable iff (!aresetn)
            bin_valid && op_q == OP_COMPACT && tx_cnt_q[1:0] == 2'h3 |-> bin_out.data == 8'h00;
    endproperty
    a_zero_top: assert property (p_zero_top) else $error("compact top byte not zero"); // RULE18

    property p_range_err;
        @(posedge aclk) disable iff (!aresetn)
            cmd_go && state_q == S_IDLE && op_in == OP_IEEE && (17'(j_in) + 17'(k_in)) > 17'(count_q)
            |=> err_q && state_q == S_IDLE ##1 !bin_valid;
    endproperty
    a_range_err: assert property (p_range_err) else $error("overrun read not refused"); // RULE11

    property p_reset_zero;
        @(posedge aclk) disable iff (!aresetn)
            wr_fire && aw_addr_q == REG_STORE && w_data_q[STO_RESET_BIT] |=> count_q == '0 && !run_q;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("buffer reset left points"); // RULE21

    property p_word_count;
        @(posedge aclk) disable iff (!aresetn)
            fmt_valid && fmt_out.last |-> wd_cnt_q + 1'b1 == (op_q == OP_ASCII ? XFER_W'(k_q) : XFER_W'(n_q));
    endproperty
    a_word_count: assert property (p_word_count) else $error("wrong number of answer words"); // RULE5
endmodule : brch_handler
`default_nettype wire

// ---- src/brch_pkg.sv ----
// package: constants and types of the buffer readout command handler
`default_nettype none
package brch_pkg;
    localparam int         ADDR_W    = 8;
    localparam int         BUF_DEPTH = 16;
    localparam int         PTR_W     = 4;
    localparam int         CNT_W     = 5;
    localparam int         NSLOT     = 12;
    localparam int         MAX_SEL   = 6;
    localparam int         SEL_W     = 4;
    localparam int         FRAC_W    = 23;
    localparam int         XFER_W    = 18;
    // register byte offsets
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_SEL    = 8'h04;
    localparam logic [7:0] REG_RANGE  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_COUNT  = 8'h10;
    localparam logic [7:0] REG_STORE  = 8'h14;
    // field positions
    localparam int         CMD_OP_W      = 4;
    localparam int         CMD_SET_BIT   = 7;
    localparam int         NSEL_LSB      = 24;
    localparam int         NSEL_W        = 3;
    localparam int         RANGE_CNT_LSB = 16;
    localparam int         ST_IDLE_BIT   = 0;
    localparam int         ST_ERR_BIT    = 1;
    localparam int         ST_RUN_BIT    = 2;
    localparam int         STO_START_BIT = 0;
    localparam int         STO_PAUSE_BIT = 1;
    localparam int         STO_RESET_BIT = 2;
    // selector limits
    localparam logic [3:0] SEL_OUT_MAX  = 4'h4;
    localparam logic [3:0] SEL_DISP_MAX = 4'h2;
    localparam logic [3:0] SEL_AUX_MAX  = 4'h4;
    localparam logic [3:0] SEL_COHERENT_SNAPSHOT_QUERY_MAX = 4'hB;
    localparam logic [3:0] SEL_BUF_MAX  = 4'h2;
    localparam logic [2:0] COHERENT_SNAPSHOT_QUERY_MIN     = 3'h2;
    localparam logic [2:0] COHERENT_SNAPSHOT_QUERY_MAX     = 3'h6;
    // answer slots; slot 0 carries the stored count
    localparam logic [3:0] SLOT_COUNT     = 4'h0;
    localparam logic [3:0] SLOT_AUX_BASE  = 4'h4;
    localparam logic [3:0] SLOT_DISP_BASE = 4'h9;
    // exponent handling of compact and ieee points
    localparam logic [8:0] CMP_EXP_BIAS  = 9'h07C;
    localparam logic [8:0] IEEE_EXP_BIAS = 9'h07F;
    localparam logic [8:0] IEEE_EXP_MAX  = 9'h0FE;
    localparam logic [7:0] IEEE_EXP_INF  = 8'hFF;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    typedef enum logic [3:0] {
        OP_OUTPUT  = 4'h1,
        OP_DISPLAY = 4'h2,
        OP_COHERENT_SNAPSHOT_QUERY    = 4'h3,
        OP_AUX     = 4'h4,
        OP_COUNT   = 4'h5,
        OP_ASCII   = 4'h6,
        OP_IEEE    = 4'h7,
        OP_COMPACT = 4'h8
    } brch_op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_WORD = 3'b010,
        S_BUF  = 3'b100
    } brch_state_t;

    // ieee singles, except disp1/disp2 which are compact points
    typedef struct packed {
        logic [31:0]       x;
        logic [31:0]       y;
        logic [31:0]       r;
        logic [31:0]       phase;
        logic [3:0][31:0]  aux;
        logic [31:0]       freq;
        logic [31:0]       disp1;
        logic [31:0]       disp2;
    } brch_meas_t;

    typedef struct packed {
        logic [31:0] data;
        logic        last;
    } brch_word_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } brch_byte_t;
endpackage : brch_pkg
`default_nettype wire

// ---- testbench/brch_host_model.sv ----
// host side sink that records binary bytes and formatter words
`default_nettype none
module brch_host_model
    import brch_pkg::*;
(
    // clock
    input wire logic       aclk,
    // traffic from the handler
    input wire brch_byte_t bin_out,
    input wire logic       bin_valid,
    input wire brch_word_t fmt_out,
    input wire logic       fmt_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0]  rx_q[$];
    logic [32:0] wd_q[$];
    always @(posedge aclk) begin
        if (bin_valid === 1'b1) rx_q.push_back(bin_out);
        if (fmt_valid === 1'b1) wd_q.push_back(fmt_out);
    end
endmodule : brch_host_model
`default_nettype wire

// ---- testbench/buffer_readout_command_handler_tb.sv ----
// register-level bench of the buffer readout command handler
`default_nettype none
module buffer_readout_command_handler_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import brch_pkg::*;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, sample_stb = 0;
    logic        awready, wready, bvalid, arready, rvalid, fmt_valid, bin_valid;
    logic [1:0]  bresp, rresp, rs;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rv;
    brch_meas_t  meas;
    brch_word_t  fmt_out;
    brch_byte_t  bin_out;
    int          n_mismatch = 0, checks_done = 0;
    brch_handler dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .meas(meas), .sample_stb(sample_stb), .fmt_out(fmt_out),
        .fmt_valid(fmt_valid), .bin_out(bin_out), .bin_valid(bin_valid));
    brch_host_model host_u (.aclk(aclk), .bin_out(bin_out), .bin_valid(bin_valid), .fmt_out(fmt_out),
        .fmt_valid(fmt_valid));
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    // distinct word per snapshot slot
    function automatic logic [31:0] wv(input int s);
        return {8'h40, 8'h7C, 8'(s), 8'h11};
    endfunction : wv
    task automatic summarize();
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic ok);
        checks_done++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("unexpected at %0t: value differs", $time);
        end
    endtask : chk
    task automatic tmo(input int n);
        if (n >= 60) begin
            n_mismatch++;
            $display("unexpected at %0t: no answer", $time);
            summarize();
        end
    endtask : tmo
    // entered after an edge; a spare edge parts calls
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (bvalid !== 1'b1 && n < 60) begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        tmo(n);
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (rvalid !== 1'b1 && n < 60) begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
        tmo(n);
        @(posedge aclk);
    endtask : rd
    task automatic cmd(input logic [31:0] sel, input logic [31:0] op);
        int n;
        wr(REG_SEL, sel);
        wr(REG_CMD, op);
        n = 0;
        do begin
            rd(REG_STATUS);
            n++;
        end while (rv[0] !== 1'b1 && n < 60);
        tmo(n);
    endtask : cmd
    // refused: error flag up, nothing sent
    task automatic chk_err(input logic [31:0] sel, input logic [31:0] op);
        cmd(sel, op);
        rd(REG_STATUS);
        chk(rv[1:0] === 2'b11 && host_u.wd_q.size() == 0 && host_u.rx_q.size() == 0);
        wr(REG_STATUS, 32'h0000_0002);
    endtask : chk_err
    initial begin
        meas = {wv(1), wv(2), wv(3), wv(4), wv(8), wv(7), wv(6), wv(5), wv(9), wv(10), wv(11)};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(REG_STATUS);
        chk(rv === 32'h0000_0001);
        rd(REG_COUNT);
        chk(rv === 32'h0000_0000);
        rd(8'h20);
        chk(rs === RESP_SLVERR && rv === 32'h0000_0000);
        for (int s = 1; s < 9; s++) begin
            cmd(32'h0100_0000 | 32'(s - s / 5 * 4), 32'(s > 4 ? OP_AUX : OP_OUTPUT));
            chk(host_u.wd_q.size() == 1 && host_u.wd_q[0] === {wv(s), 1'b1});
            host_u.wd_q.delete();
        end
        cmd(32'h0300_0159, 32'(OP_COHERENT_SNAPSHOT_QUERY));
        chk({host_u.wd_q[0], host_u.wd_q[1], host_u.wd_q[2]} === {wv(9), 1'b0, wv(5), 1'b0, wv(1), 1'b1});
        chk(host_u.wd_q.size() == 3);
        cmd(32'h0100_0002, 32'(OP_DISPLAY));
        chk(host_u.wd_q[3] === {32'h4531_1000, 1'b1});
        host_u.wd_q.delete();
        $display("test queries done");
        wr(REG_RANGE, 32'h0001_0000);
        chk_err(32'h0100_0005, 32'(OP_AUX));
        chk_err(32'h0100_0001, 32'h0000_0081);
        chk_err(32'h0100_0009, 32'(OP_COHERENT_SNAPSHOT_QUERY));
        chk_err(32'h0100_0001, 32'(OP_ASCII));
        $display("test refusals done");
        wr(REG_STORE, 32'h0000_0001);
        for (int k = 1; k < 4; k++) begin
            meas.disp1 <= {8'hAB, 8'h7C, 8'(k), 8'h22};
            sample_stb <= 1'b1;
            @(posedge aclk);
            sample_stb <= 1'b0;
            @(posedge aclk);
        end
        wr(REG_STORE, 32'h0000_0002);
        rd(REG_COUNT);
        chk(rv === 32'h0000_0003);
        wr(REG_RANGE, 32'h0002_0001);
        wr(REG_SEL, 32'h0100_0001);
        wr(REG_CMD, 32'(OP_COMPACT));
        rd(REG_STATUS);
        chk(rv[0] === 1'b0);
        cmd(32'h0100_0001, 32'h0000_0000);
        wr(REG_STATUS, 32'h0000_0002);
        chk(host_u.rx_q.size() == 8);
        for (int b = 0; b < 8; b++) chk(host_u.rx_q[b] === {(b % 4 == 0) ? 8'h22 : (b % 4 == 1) ? 8'(b / 4 + 2) :
            (b % 4 == 2) ? 8'h7C : 8'h00, b == 7});
        host_u.rx_q.delete();
        wr(REG_RANGE, 32'h0003_0000);
        cmd(32'h0100_0002, 32'(OP_IEEE));
        chk(host_u.rx_q.size() == 12 && host_u.rx_q[11][0] === 1'b1 && host_u.rx_q[10][0] === 1'b0);
        chk({host_u.rx_q[3][8:1], host_u.rx_q[2][8:1], host_u.rx_q[1][8:1], host_u.rx_q[0][8:1]} === 32'h4531_1000);
        host_u.rx_q.delete();
        cmd(32'h0100_0001, 32'(OP_ASCII));
        chk(host_u.wd_q.size() == 3 && host_u.wd_q[2][0] === 1'b1 && host_u.wd_q[1][0] === 1'b0);
        wr(REG_RANGE, 32'h0002_0002);
        host_u.wd_q.delete();
        chk_err(32'h0100_0001, 32'(OP_IEEE));
        wr(REG_STORE, 32'h0000_0004);
        rd(REG_COUNT);
        chk(rv === 32'h0000_0000);
        $display("test buffer reads done");
        summarize();
    end
endmodule : buffer_readout_command_handler_tb
`default_nettype wire
